// File: inc/icr_defs.svh
// Constants for the interrupt command register block.
// Assumes a word-indexed register port; offsets are word indices.
// What this block does
// - A disable command write disables every source whose bit is one.
// - A clear command write clears the pending state of every source written one, unless that source's edge arrives in the same cycle.
// - A set command write sets pending for sources written one; zero bits do nothing.
// - Any write to the end-of-interrupt location, whatever data, ends the interrupt.
// - A stored spurious handler address is returned on spurious normal or fast vector reads.
// - Debug control bit 0 is a read/write protection mode bit.
// - Debug control bit 1 is a general mask that holds both processor lines inactive.
// - A fast forcing enable write enables forcing for system or peripheral sources written one; bit 0 reserved.
// - A fast forcing disable write disables forcing for sources written one, others unchanged.
// - The fast forcing status register reads one per forced source, bit 0 reserved as zero.
// - An enable command write enables every source whose bit is one.
`ifndef ICR_DEFS_SVH
`define ICR_DEFS_SVH
`define ICR_ADDR_W      4
`define ICR_IDX_ENABLE  4'h0
`define ICR_IDX_DISABLE 4'h1
`define ICR_IDX_CLEAR   4'h2
`define ICR_IDX_SET     4'h3
`define ICR_IDX_EOI     4'h4
`define ICR_IDX_SPU     4'h5
`define ICR_IDX_DCR     4'h6
`define ICR_IDX_FFEN    4'h7
`define ICR_IDX_FFDIS   4'h8
`define ICR_IDX_FFSTAT  4'h9
`define ICR_IDX_ENSTAT  4'ha
`define ICR_IDX_PEND    4'hb
`define ICR_IDX_LINES   4'hc
`define ICR_IDX_NVEC    4'hd
`define ICR_IDX_FVEC    4'he
`define ICR_DCR_PROTECTION_MODE_BIT    0
`define ICR_DCR_GENERAL_MASK_BIT    1
`define ICR_FAST_SRC    0
`define ICR_ZERO32      32'h0000_0000
`define ICR_FF_MASK     32'hffff_fffe
`endif

// File: inc/icr_pkg.sv
// Types for the interrupt command register block.
// Assumes the defs header is on the include path.
package icr_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } icr_req_t;
    typedef struct packed {
        logic protection_mode_bit;
        logic general_mask_bit;
    } icr_dcr_t;
endpackage

// File: core/icr_regs.sv
// Command, status and debug control registers of the interrupt controller.
// Assumes single-cycle strobes synchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "icr_defs.svh"
module icr_regs
    import icr_pkg::*;
#(
    parameter int NSRC = 32
) (
    input  wire logic              ref_clk_i,
    input  wire logic              reset_n_i,
    input  wire icr_req_t          req_i,
    output logic [31:0]            rdata_o,
    input  wire logic [NSRC-1:0]   src_edge_i,
    input  wire logic              irq_req_i,
    input  wire logic              fiq_req_i,
    input  wire logic              irq_spurious_i,
    input  wire logic              fiq_spurious_i,
    input  wire logic [31:0]       irq_vector_i,
    input  wire logic [31:0]       fiq_vector_i,
    output logic [NSRC-1:0]        enabled_o,
    output logic [NSRC-1:0]        pending_o,
    output logic [NSRC-1:0]        fast_force_o,
    output logic                   eoi_o,
    output logic                   protection_mode_bit_o,
    output logic                   processor_normal_line_n_o,
    output logic                   processor_fast_line_n_o
);
    logic [NSRC-1:0] enable_q;
    logic [NSRC-1:0] pend_q;
    logic [NSRC-1:0] force_q;
    logic [31:0]     spu_q;
    icr_dcr_t        dcr_q;
    logic            eoi_q;
    logic            nline_q;
    logic            fline_q;
    logic [31:0]     rdata_q;
    logic            wr_en;
    logic            wr_dis;
    logic            wr_clr;
    logic            wr_set;
    logic            wr_ffe;
    logic            wr_ffd;

    // Command decode; zero bits in the data leave state untouched
    assign wr_en  = req_i.wr && (req_i.addr == `ICR_IDX_ENABLE);
    assign wr_dis = req_i.wr && (req_i.addr == `ICR_IDX_DISABLE);
    assign wr_clr = req_i.wr && (req_i.addr == `ICR_IDX_CLEAR);
    assign wr_set = req_i.wr && (req_i.addr == `ICR_IDX_SET);
    assign wr_ffe = req_i.wr && (req_i.addr == `ICR_IDX_FFEN);
    assign wr_ffd = req_i.wr && (req_i.addr == `ICR_IDX_FFDIS);

    // Per-source enable, pending and forcing state
    genvar i;
    generate
        for (i = 0; i < NSRC; i++) begin : g_src
            // Enable mask; disable wins if both ever meet
            always_ff @(posedge ref_clk_i) begin
                if (!reset_n_i) begin
                    enable_q[i] <= 1'b0;
                end else if (wr_dis && req_i.wdata[i]) begin
                    enable_q[i] <= 1'b0;
                end else if (wr_en && req_i.wdata[i]) begin
                    enable_q[i] <= 1'b1;
                end
            end
            // Pending: a hardware edge beats a software clear
            always_ff @(posedge ref_clk_i) begin
                if (!reset_n_i) begin
                    pend_q[i] <= 1'b0;
                end else if (src_edge_i[i] || (wr_set && req_i.wdata[i])) begin
                    pend_q[i] <= 1'b1;
                end else if (wr_clr && req_i.wdata[i]) begin
                    pend_q[i] <= 1'b0;
                end
            end
            // The fast source itself can never be forced
            if (i == `ICR_FAST_SRC) begin : g_nf
                // Kept procedural so every bit of the vector has one kind of driver
                always_ff @(posedge ref_clk_i) begin
                    force_q[i] <= 1'b0;
                end
            end else begin : g_f
                always_ff @(posedge ref_clk_i) begin
                    if (!reset_n_i) begin
                        force_q[i] <= 1'b0;
                    end else if (wr_ffd && req_i.wdata[i]) begin
                        force_q[i] <= 1'b0;
                    end else if (wr_ffe && req_i.wdata[i]) begin
                        force_q[i] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // End-of-interrupt pulse on any write to the EOI location, data ignored
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            eoi_q <= 1'b0;
        end else begin
            eoi_q <= req_i.wr && (req_i.addr == `ICR_IDX_EOI);
        end
    end

    // Spurious handler address, software owned
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            spu_q <= `ICR_ZERO32;
        end else if (req_i.wr && (req_i.addr == `ICR_IDX_SPU)) begin
            spu_q <= req_i.wdata;
        end
    end

    // Debug control: protection and general mask
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            dcr_q <= '0;
        end else if (req_i.wr && (req_i.addr == `ICR_IDX_DCR)) begin
            dcr_q.protection_mode_bit <= req_i.wdata[`ICR_DCR_PROTECTION_MODE_BIT];
            dcr_q.general_mask_bit <= req_i.wdata[`ICR_DCR_GENERAL_MASK_BIT];
        end
    end

    // Processor lines, active low, registered to stay glitch free
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            nline_q <= 1'b1;
            fline_q <= 1'b1;
        end else begin
            nline_q <= !(irq_req_i && !dcr_q.general_mask_bit);
            fline_q <= !(fiq_req_i && !dcr_q.general_mask_bit);
        end
    end

    // Read mux; command registers read zero, reads have no side effect
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rdata_q <= `ICR_ZERO32;
        end else if (req_i.rd) begin
            case (req_i.addr)
                `ICR_IDX_SPU:    rdata_q <= spu_q;
                `ICR_IDX_DCR:    rdata_q <= 32'(dcr_q.protection_mode_bit)
                                          | (32'(dcr_q.general_mask_bit) << `ICR_DCR_GENERAL_MASK_BIT);
                `ICR_IDX_FFSTAT: rdata_q <= 32'(force_q) & `ICR_FF_MASK;
                `ICR_IDX_ENSTAT: rdata_q <= 32'(enable_q);
                `ICR_IDX_PEND:   rdata_q <= 32'(pend_q);
                `ICR_IDX_LINES:  rdata_q <= {30'h0000_0000, !nline_q, !fline_q};
                `ICR_IDX_NVEC:   rdata_q <= irq_spurious_i ? spu_q
                                                           : irq_vector_i;
                `ICR_IDX_FVEC:   rdata_q <= fiq_spurious_i ? spu_q
                                                           : fiq_vector_i;
                default:         rdata_q <= `ICR_ZERO32;
            endcase
        end else begin
            rdata_q <= `ICR_ZERO32;
        end
    end

    assign rdata_o                   = rdata_q;
    assign enabled_o                 = enable_q;
    assign pending_o                 = pend_q;
    assign fast_force_o              = force_q;
    assign eoi_o                     = eoi_q;
    assign protection_mode_bit_o                    = dcr_q.protection_mode_bit;
    assign processor_normal_line_n_o = nline_q;
    assign processor_fast_line_n_o   = fline_q;
endmodule
`default_nettype wire

// File: verification/icr_prio_model.sv
// Stand-in for the priority logic beside the registers.
// Assumes the bench picks the requests and spurious flags.
`timescale 1ns/1ps
`default_nettype none
module icr_prio_model (
    input  wire logic [3:0]  ctl_i,
    output logic [3:0]       flags_o,
    output logic [31:0]      nvec_o,
    output logic [31:0]      fvec_o
);
    // Flags: normal req, fast req, normal spurious, fast spurious
    assign flags_o = ctl_i;
    // Handler addresses kept apart from the spurious one
    assign nvec_o = 32'h0000_1100;
    assign fvec_o = 32'h0000_2200;
endmodule
`default_nettype wire

// File: verification/icr_regs_checker.sv
// Port assertions for the command register block.
// Assumes a bind onto icr_regs; bit n is source n.
`timescale 1ns/1ps
`default_nettype none
module icr_regs_checker
    import icr_pkg::*;
#(
    parameter int NSRC = 32
) (
    input wire logic            ref_clk_i,
    input wire logic            reset_n_i,
    input wire icr_req_t        req_i,
    input wire logic [NSRC-1:0] src_edge_i,
    input wire logic [NSRC-1:0] enabled_o,
    input wire logic [NSRC-1:0] pending_o,
    input wire logic [NSRC-1:0] fast_force_o,
    input wire logic            eoi_o,
    input wire logic            protection_mode_bit_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // One-hot write decode keeps each property short
    wire logic [15:0]     w = req_i.wr ? 16'h1 << req_i.addr : 16'h0;
    wire logic [NSRC-1:0] d = req_i.wdata[NSRC-1:0];
    a_enable_sets: assert property (w[0] |=>
        enabled_o == ($past(enabled_o) | $past(d))) else $error("enable");
    a_disable_clr: assert property (w[1] |=>
        enabled_o == ($past(enabled_o) & ~$past(d))) else $error("disable");
    a_clear_pend: assert property (w[2] |=> pending_o ==
        ($past(pending_o) & ~$past(d) | $past(src_edge_i))) else $error("clr");
    a_set_pend: assert property (w[3] |=> pending_o ==
        ($past(pending_o) | $past(d) | $past(src_edge_i))) else $error("set");
    a_eoi_pulse: assert property (eoi_o == $past(w[4]))
        else $error("eoi");
    a_protection_mode_bit_bit: assert property (w[6] |=> protection_mode_bit_o == $past(d[0]))
        else $error("protection_mode_bit");
    a_ff_enable: assert property (w[7] |=> fast_force_o ==
        (($past(fast_force_o) | $past(d)) & ~NSRC'(1))) else $error("ffen");
    a_ff_disable: assert property (w[8] |=> fast_force_o ==
        ($past(fast_force_o) & ~$past(d))) else $error("ffdis");
endmodule
bind icr_regs icr_regs_checker #(.NSRC(NSRC)) chk (.ref_clk_i, .reset_n_i,
    .req_i, .src_edge_i, .enabled_o, .pending_o, .fast_force_o, .eoi_o,
    .protection_mode_bit_o);
`default_nettype wire

// File: verification/icr_regs_tb.sv
// Self-checking bench for the command register block.
// Assumes icr_regs with 32 sources and the priority stand-in.
`timescale 1ns/1ps
`default_nettype none
module icr_regs_tb;
    import icr_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    icr_req_t    req = '0;
    logic [31:0] src = 32'h0;
    logic [3:0]  ctl = 4'h0;
    logic [3:0]  fl;
    logic [31:0] rd, en, pd, ff, nv, fv;
    logic        eoi, protection_mode_bit, nl_n, fl_n;
    int          err_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    icr_prio_model pm (.ctl_i(ctl), .flags_o(fl), .nvec_o(nv), .fvec_o(fv));
    icr_regs #(.NSRC(32)) uut (.ref_clk_i, .reset_n_i, .req_i(req),
        .rdata_o(rd), .src_edge_i(src), .irq_req_i(fl[3]),
        .fiq_req_i(fl[2]), .irq_spurious_i(fl[1]), .fiq_spurious_i(fl[0]),
        .irq_vector_i(nv), .fiq_vector_i(fv), .enabled_o(en),
        .pending_o(pd), .fast_force_o(ff), .eoi_o(eoi), .protection_mode_bit_o(protection_mode_bit),
        .processor_normal_line_n_o(nl_n), .processor_fast_line_n_o(fl_n));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard, far above the roughly 60 cycles needed
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // One bus cycle; returns 1 ns after the taking edge, when data stand
    task automatic acc(logic w, logic [3:0] a, logic [31:0] d);
        @(posedge ref_clk_i);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk_i);
        req <= '0;
        #1;
    endtask
    task automatic settle(logic [3:0] c);
        @(posedge ref_clk_i);
        ctl <= c;
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic t_mask();
        acc(1, 4'h0, 32'h8000_00f3);
        cmp("enabled", 32'h8000_00f3, en);
        acc(1, 4'h1, 32'h0000_0011);
        cmp("enabled", 32'h8000_00e2, en);
        acc(0, 4'h1, 0);
        cmp("wo read", 0, rd);
    endtask
    task automatic t_pend();
        acc(1, 4'h3, 32'h8000_0005);
        acc(1, 4'h2, 32'h0000_0001);
        acc(1, 4'h3, 0);
        cmp("pending", 32'h8000_0004, pd);
        // Source pulse meets a clear of the same bit; the pulse wins
        fork
            acc(1, 4'h2, 32'h0000_0200);
            begin
                @(posedge ref_clk_i);
                src <= 32'h0000_0200;
                @(posedge ref_clk_i);
                src <= 32'h0;
            end
        join
        cmp("pending edge", 32'h8000_0204, pd);
        acc(1, 4'h4, 32'h0);
        cmp("eoi", 1, eoi);
    endtask
    task automatic t_spu();
        acc(1, 4'h5, 32'h1234_5678);
        settle(4'h3);
        acc(0, 4'hd, 0);
        cmp("normal vec", 32'h1234_5678, rd);
        acc(0, 4'he, 0);
        cmp("fast vec", 32'h1234_5678, rd);
        acc(0, 4'h5, 0);
        cmp("spurious store", 32'h1234_5678, rd);
        // Not spurious: the stand-in handler addresses come through
        settle(4'h0);
        acc(0, 4'hd, 0);
        cmp("normal vec", 32'h0000_1100, rd);
        acc(0, 4'he, 0);
        cmp("fast vec", 32'h0000_2200, rd);
    endtask
    task automatic t_dcr();
        settle(4'hc);
        acc(1, 4'h6, 32'h3);
        settle(4'hc);
        cmp("lines", 32'h7, 32'({protection_mode_bit, nl_n, fl_n}));
        acc(0, 4'h6, 0);
        cmp("debug ctrl", 32'h3, rd);
        acc(1, 4'h6, 32'h0);
        settle(4'hc);
        cmp("lines", 32'h0, 32'({protection_mode_bit, nl_n, fl_n}));
        acc(0, 4'hc, 0);
        cmp("line status", 32'h3, rd);
    endtask
    task automatic t_ff();
        acc(1, 4'h7, 32'hffff_ffff);
        acc(1, 4'h8, 32'h0000_0006);
        acc(0, 4'h9, 0);
        cmp("force", 32'hffff_fff8, rd);
        cmp("force out", 32'hffff_fff8, ff);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        t_mask();
        t_pend();
        t_spu();
        t_dcr();
        t_ff();
        tally_and_finish();
    end
endmodule
`default_nettype wire
